/* File: rcms_pkg.sv */
// constants shared by the receiver control and mode-select logic
// assumes a single 10 MHz core clock and an active-low async reset
// What this block does
// - interface pin high selects serial control mode
// - device select low ignores bus, keeps config
// - answer only address 1010000, any direction
// - source-select bits reset to pin control
// - rate pins decode to eight preset rates
// - power-on reset restores all register defaults
// - auto bandwidth, max at start, field overrides
// - one limiter active, other sleeps, one routed
// - channel pin high picks channel one
// - source bit set uses register channel bit
// - demux ratio from pins or register
// - line loopback only while its enable low
// - diagnostic loopback only while enable low
// - dual limiter bit keeps both awake
package rcms_pkg;
    // bus address of the device
    localparam logic [6:0] RCMS_DEV_ADDR = 7'h50;
    // register offsets
    localparam logic [7:0] RCMS_OFS_LIMCFG = 8'hc2;
    localparam logic [7:0] RCMS_OFS_DMXCFG = 8'hc3;
    // reset values: pin control, automatic bandwidth, no dual limiter
    localparam logic [7:0] RCMS_RST_LIMCFG = 8'h00;
    localparam logic [7:0] RCMS_RST_DMXCFG = 8'h00;
    // limiter_config field positions
    localparam int RCMS_LIM_CHSRC = 7;
    localparam int RCMS_LIM_CHSEL = 6;
    localparam int RCMS_LIM_DUAL = 5;
    localparam int RCMS_LIM_BWOVR = 4;
    localparam int RCMS_LIM_BW_HI = 3;
    localparam int RCMS_LIM_BW_LO = 0;
    // demux_config field positions
    localparam int RCMS_DMX_SRC = 7;
    localparam int RCMS_DMX_R_HI = 1;
    localparam int RCMS_DMX_R_LO = 0;
    // bandwidth code for maximum bandwidth
    localparam logic [3:0] RCMS_BW_MAX = 4'hf;
    // demux ratio codes
    typedef enum logic [1:0] {
        RCMS_DMX_16 = 2'h0,
        RCMS_DMX_10 = 2'h1,
        RCMS_DMX_8 = 2'h2,
        RCMS_DMX_4 = 2'h3
    } rcms_ratio_t;
    // preset rate codes, index of rate pins
    typedef enum logic [2:0] {
        RCMS_R155 = 3'h0,
        RCMS_R622 = 3'h1,
        RCMS_R2488 = 3'h2,
        RCMS_R2666 = 3'h3,
        RCMS_R1250 = 3'h4,
        RCMS_R3125 = 3'h5,
        RCMS_R1062 = 3'h6,
        RCMS_R2125 = 3'h7
    } rcms_rate_t;
    // automatic bandwidth code per preset rate
    function automatic logic [3:0] rcms_auto_bw(input logic [2:0] rate);
        unique case (rate)
            3'h0: rcms_auto_bw = 4'h2;
            3'h1: rcms_auto_bw = 4'h6;
            3'h6: rcms_auto_bw = 4'ha;
            3'h4: rcms_auto_bw = 4'hb;
            3'h7: rcms_auto_bw = 4'hd;
            3'h2: rcms_auto_bw = 4'he;
            default: rcms_auto_bw = RCMS_BW_MAX;
        endcase
    endfunction
endpackage

/* File: rcms_serial_slave.sv */
// two-wire serial slave with byte register read and write
// assumes scl and sda already synchronised to core_clk
`timescale 1ns/1ns
`default_nettype none
module rcms_serial_slave
    import rcms_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic enable,
    input wire logic scl,
    input wire logic sda,
    output logic sda_oe,
    output logic wr_stb,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);
    typedef enum {ST_IDLE, ST_DEV, ST_DACK, ST_REG, ST_RACK, ST_WDAT, ST_WACK,
                  ST_RDAT, ST_RACKM} rcms_sst_t;
    rcms_sst_t state;
    logic scl_q, sda_q;          // previous samples
    logic [7:0] shreg;           // shift register
    logic [3:0] bitcnt;          // bits in current byte
    logic rnw;                   // read transfer
    logic [7:0] ptr;             // register pointer
    logic ack_drv;               // pulls sda low
    wire scl_rise = scl & ~scl_q;
    wire scl_fall = ~scl & scl_q;
    wire start_c = enable & scl & scl_q & sda_q & ~sda;
    wire stop_c = enable & scl & scl_q & ~sda_q & sda;
    wire [7:0] byte_in = {shreg[6:0], sda};
    assign rd_addr = ptr;
    assign wr_addr = ptr;
    assign sda_oe = ack_drv;
    ////////////////////////////////////////////////////////////////////
    // protocol engine
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            shreg <= 8'h00;
            bitcnt <= 4'h0;
            rnw <= 1'b0;
            ptr <= 8'h00;
            ack_drv <= 1'b0;
            wr_stb <= 1'b0;
            wr_data <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            wr_stb <= 1'b0;
            if (!enable || stop_c) begin
                // deselect aborts, config kept
                state <= ST_IDLE;
                ack_drv <= 1'b0;
            end else if (start_c) begin
                state <= ST_DEV;
                bitcnt <= 4'h0;
                ack_drv <= 1'b0;
            end else if (scl_rise && bitcnt != 4'h8) begin
                // msb first sampling
                shreg <= byte_in;
                bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall) begin
                unique case (state)
                    ST_IDLE: ;
                    ST_DEV: if (bitcnt == 4'h8) begin
                        // address match, r/w bit free
                        if (shreg[7:1] == RCMS_DEV_ADDR) begin
                            rnw <= shreg[0];
                            ack_drv <= 1'b1;
                            state <= ST_DACK;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                    ST_DACK: begin
                        bitcnt <= 4'h0;
                        if (rnw) begin
                            shreg <= rd_data;
                            ack_drv <= ~rd_data[7];
                            state <= ST_RDAT;
                        end else begin
                            ack_drv <= 1'b0;
                            state <= ST_REG;
                        end
                    end
                    ST_REG: if (bitcnt == 4'h8) begin
                        ptr <= shreg;
                        ack_drv <= 1'b1;
                        state <= ST_RACK;
                    end
                    ST_RACK, ST_WACK: begin
                        ack_drv <= 1'b0;
                        bitcnt <= 4'h0;
                        state <= ST_WDAT;
                    end
                    ST_WDAT: if (bitcnt == 4'h8) begin
                        wr_data <= shreg;
                        wr_stb <= 1'b1;
                        ack_drv <= 1'b1;
                        state <= ST_WACK;
                    end
                    ST_RDAT: if (bitcnt == 4'h8) begin
                        ack_drv <= 1'b0;
                        ptr <= ptr + 8'h01;
                        state <= ST_RACKM;
                    end else begin
                        // next bit out, msb first; every scl rise has
                        // shifted once, so the next bit is always at the top
                        ack_drv <= ~shreg[7];
                    end
                    ST_RACKM: if (!sda) begin
                        shreg <= rd_data;
                        bitcnt <= 4'h0;
                        ack_drv <= ~rd_data[7];
                        state <= ST_RDAT;
                    end else begin
                        state <= ST_IDLE;
                    end
                    default: state <= ST_IDLE;
                endcase
                if (state == ST_WACK) ptr <= ptr + 8'h01;
            end
        end
    end
    // no write strobe while deselected
    a_strobe_enabled: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_stb |-> $past(enable)) else $error("write while deselected");
endmodule
`default_nettype wire

/* File: rcms_top.sv */
// receiver control: mode, channel, limiter, demux and loopback selection
// assumes pins are asynchronous and synchronised here
`timescale 1ns/1ns
`default_nettype none
module rcms_top
    import rcms_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic interface_select_pin,
    input wire logic cs_rate_select_0,
    input wire logic sda_rate_select_1_in,
    output logic sda_rate_select_1_out,
    output logic sda_rate_select_1_oe,
    input wire logic scl_rate_select_2,
    input wire logic channel_select,
    input wire logic ratio_pin_0,
    input wire logic ratio_pin_1,
    input wire logic line_loopback_enable_n,
    input wire logic diag_loopback_enable_n,
    output logic serial_mode,
    output logic [2:0] rate_code,
    output logic channel1_route,
    output logic limiter1_awake,
    output logic limiter2_awake,
    output logic [3:0] limiter_bandwidth,
    output logic [1:0] demux_ratio,
    output logic line_loopback_on,
    output logic diag_loopback_on
);
    ////////////////////////////////////////////////////////////////////
    // pin synchronisers, two flops each
    localparam int NS = 9;
    logic [NS-1:0] s1, s2;
    wire [NS-1:0] raw = {interface_select_pin, cs_rate_select_0, sda_rate_select_1_in,
                         scl_rate_select_2, channel_select, ratio_pin_1, ratio_pin_0,
                         line_loopback_enable_n, diag_loopback_enable_n};
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s1 <= '1;
            s2 <= '1;
        end else begin
            s1 <= raw;
            s2 <= s1;
        end
    end
    wire ui_s = s2[8];
    wire cs_s = s2[7];
    wire sda_s = s2[6];
    wire scl_s = s2[5];
    wire chsel_s = s2[4];
    wire [1:0] rpin_s = s2[3:2];
    wire lle_n_s = s2[1];
    wire dle_n_s = s2[0];
    ////////////////////////////////////////////////////////////////////
    // mode selection: high or open pin gives serial control
    wire bus_en = ui_s & cs_s;
    ////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [7:0] limiter_config; // channel source, channel, dual, bw
    logic [7:0] demux_config;   // ratio source, ratio
    logic wr_stb;
    logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
    rcms_serial_slave u_slave (
        .core_clk(core_clk),
        .rstn(rstn),
        .enable(bus_en),
        .scl(scl_s),
        .sda(sda_s),
        .sda_oe(sda_rate_select_1_oe),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );
    assign sda_rate_select_1_out = 1'b0;
    // register read mux, unmapped read as zero
    assign rd_data = (rd_addr == RCMS_OFS_LIMCFG) ? limiter_config :
                     (rd_addr == RCMS_OFS_DMXCFG) ? demux_config : 8'h00;
    // reset restores defaults whatever mode
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            limiter_config <= RCMS_RST_LIMCFG;
            demux_config <= RCMS_RST_DMXCFG;
        end else if (wr_stb && ui_s) begin
            if (wr_addr == RCMS_OFS_LIMCFG) limiter_config <= wr_data;
            if (wr_addr == RCMS_OFS_DMXCFG) demux_config <= wr_data;
        end
    end
    // in preset mode the registers read as defaults
    wire [7:0] lim_eff = ui_s ? limiter_config : RCMS_RST_LIMCFG;
    wire [7:0] dmx_eff = ui_s ? demux_config : RCMS_RST_DMXCFG;
    ////////////////////////////////////////////////////////////////////
    // rate decode from pins in preset mode
    wire [2:0] rate_pins = {scl_s, sda_s, cs_s};
    // channel choice
    wire ch_src = lim_eff[RCMS_LIM_CHSRC];
    wire next_ch1 = ch_src ? lim_eff[RCMS_LIM_CHSEL] : chsel_s;
    wire dual = lim_eff[RCMS_LIM_DUAL];
    // bandwidth: max in serial mode, auto from rate pins in preset mode, register override
    wire [3:0] auto_bw = ui_s ? RCMS_BW_MAX : rcms_auto_bw(rate_pins);
    wire [3:0] next_bw = lim_eff[RCMS_LIM_BWOVR] ?
                         lim_eff[RCMS_LIM_BW_HI:RCMS_LIM_BW_LO] : auto_bw;
    wire [1:0] next_ratio = dmx_eff[RCMS_DMX_SRC] ?
                            dmx_eff[RCMS_DMX_R_HI:RCMS_DMX_R_LO] : rpin_s;
    ////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            serial_mode <= 1'b1;
            rate_code <= 3'h0;
            channel1_route <= 1'b1;
            limiter1_awake <= 1'b1;
            limiter2_awake <= 1'b0;
            limiter_bandwidth <= RCMS_BW_MAX;
            demux_ratio <= 2'h0;
            line_loopback_on <= 1'b0;
            diag_loopback_on <= 1'b0;
        end else begin
            serial_mode <= ui_s;
            rate_code <= ui_s ? rate_code : rate_pins;
            channel1_route <= next_ch1;
            limiter1_awake <= next_ch1 | dual;
            limiter2_awake <= ~next_ch1 | dual;
            limiter_bandwidth <= next_bw;
            demux_ratio <= next_ratio;
            line_loopback_on <= ~lle_n_s;
            diag_loopback_on <= ~dle_n_s;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // checks
    a_line_loop_low: assert property (@(posedge core_clk) disable iff (!rstn)
        line_loopback_on == ~$past(lle_n_s)) else $error("line loopback wrong");
    a_diag_loop_low: assert property (@(posedge core_clk) disable iff (!rstn)
        diag_loopback_on == ~$past(dle_n_s)) else $error("diag loopback wrong");
    a_one_limiter: assert property (@(posedge core_clk) disable iff (!rstn)
        !$past(dual) |-> (limiter1_awake ^ limiter2_awake)) else $error("limiters");
    a_dual_both: assert property (@(posedge core_clk) disable iff (!rstn)
        $past(dual) |-> (limiter1_awake && limiter2_awake)) else $error("dual");
    a_pin_channel: assert property (@(posedge core_clk) disable iff (!rstn)
        !$past(ch_src) |-> channel1_route == $past(chsel_s)) else $error("pin ch");
    a_reg_channel: assert property (@(posedge core_clk) disable iff (!rstn)
        $past(ch_src) |-> channel1_route == $past(lim_eff[6])) else $error("reg ch");
    a_preset_keep: assert property (@(posedge core_clk) disable iff (!rstn)
        !ui_s |=> $stable(limiter_config)) else $error("preset write");
    a_preset_rate: assert property (@(posedge core_clk) disable iff (!rstn)
        !$past(ui_s) |-> rate_code == $past(rate_pins)) else $error("rate");
endmodule
`default_nettype wire

/* File: rcms_host_model.sv */
// serial bus host model for the shared select, data and clock pins
// assumes the bench ties sda_rel and the device pull-down into sda_bus
`timescale 1ns/1ns
`default_nettype none
module rcms_host_model (
    input wire logic core_clk,
    input wire logic sda_bus,
    output var logic cs,
    output var logic sda_rel,
    output var logic scl
);
    ////////////////////////////////////////////////////////////////////////
    // idle: not selected, clock and data released high
    initial begin
        cs = 1'b0;
        sda_rel = 1'b1;
        scl = 1'b1;
    end
    // one half period of the bus clock, well above the sync latency
    task automatic half();
        repeat (5) @(negedge core_clk);
    endtask
    // drive all three shared pins at once, also used as preset rate pins
    task automatic pins(input logic [2:0] v);
        @(negedge core_clk);
        {scl, sda_rel, cs} = v;
    endtask
    // one bit, data only moves while the clock is low
    task automatic bit_io(input logic b, output logic seen);
        sda_rel = b;
        half();
        scl = 1'b1;
        half();
        seen = sda_bus;
        scl = 1'b0;
        half();
    endtask
    // start or repeated start
    task automatic start_cond();
        sda_rel = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_rel = 1'b0;
        half();
        scl = 1'b0;
        half();
    endtask
    // byte plus acknowledge slot; a is what the host leaves on the ack bit
    task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q,
                           output logic s);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(a, s);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // register write or read; ok is high only if every byte the host sent was acknowledged
    task automatic xfer(input logic [6:0] dev, input logic sel, input logic [7:0] ofs,
                        input logic rd, inout logic [7:0] data, output logic ok);
        logic [7:0] q;
        logic s;
        @(negedge core_clk);
        cs = sel;
        half();
        start_cond();
        byte_io({dev, 1'b0}, 1'b1, q, s);
        ok = !s;
        byte_io(ofs, 1'b1, q, s);
        ok = ok & !s;
        if (rd) begin
            start_cond();
            byte_io({dev, 1'b1}, 1'b1, q, s);
            ok = ok & !s;
            byte_io(8'hff, 1'b1, data, s);
        end else begin
            byte_io(data, 1'b1, q, s);
            ok = ok & !s;
        end
        // stop, select dropped only after it
        sda_rel = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_rel = 1'b1;
        half();
        cs = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: receiver_control_mode_select_test.sv */
// self-checking bench for the receiver control and mode-select block
// assumes rcms_pkg, rcms_top and rcms_host_model are compiled first
`timescale 1ns/1ns
`default_nettype none
module receiver_control_mode_select_test;
    import rcms_pkg::*;
    logic core_clk, rstn, ui, ch_pin, rp0, rp1, ll_n, dl_n;
    wire logic cs, sda_rel, scl, sda_out, sda_oe, sda_bus, serial_mode;
    wire logic ch1, lim1, lim2, ll_on, dl_on;
    wire logic [2:0] rate_code;
    wire logic [3:0] bw;
    wire logic [1:0] ratio;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    // pull-up on the data line, pulled low by the device when enabled
    assign sda_bus = sda_rel & (sda_oe ? sda_out : 1'b1);
    // packed view of the selection outputs
    wire logic [7:0] view = {serial_mode, ch1, lim1, lim2, ll_on, dl_on, ratio};
    rcms_host_model host_u (.core_clk(core_clk), .sda_bus(sda_bus), .cs(cs),
        .sda_rel(sda_rel), .scl(scl));
    rcms_top dut_u (.core_clk(core_clk), .rstn(rstn), .interface_select_pin(ui),
        .cs_rate_select_0(cs), .sda_rate_select_1_in(sda_bus),
        .sda_rate_select_1_out(sda_out), .sda_rate_select_1_oe(sda_oe),
        .scl_rate_select_2(scl), .channel_select(ch_pin), .ratio_pin_0(rp0),
        .ratio_pin_1(rp1), .line_loopback_enable_n(ll_n), .diag_loopback_enable_n(dl_n),
        .serial_mode(serial_mode), .rate_code(rate_code), .channel1_route(ch1),
        .limiter1_awake(lim1), .limiter2_awake(lim2), .limiter_bandwidth(bw),
        .demux_ratio(ratio), .line_loopback_on(ll_on), .diag_loopback_on(dl_on));
    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fails++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // closing report
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // compare and count
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // let pins cross the sync flops
    task automatic settle();
        repeat (6) @(negedge core_clk);
    endtask
    // register write with expected acknowledge
    task automatic wr(input logic [6:0] dev, input logic sel, input logic [7:0] ofs,
                      input logic [7:0] d, input logic exp_ack);
        logic [7:0] v;
        logic ok;
        v = d;
        host_u.xfer(dev, sel, ofs, 1'b0, v, ok);
        chk("write ack", {7'h0, exp_ack}, {7'h0, ok});
        settle();
    endtask
    // register read with expected data
    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
        logic [7:0] v;
        logic ok;
        v = 8'h00;
        host_u.xfer(7'h50, 1'b1, ofs, 1'b1, v, ok);
        chk("read ack", 8'h01, {7'h0, ok});
        chk("read data", exp, v);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        core_clk = 1'b0;
        rstn = 1'b0;
        ui = 1'b1;
        ch_pin = 1'b1;
        {rp1, rp0} = 2'h0;
        {ll_n, dl_n} = 2'h3;
        repeat (12) @(negedge core_clk);
        rstn = 1'b1;
        settle();
        chk("view", 8'he0, view);
        chk("bandwidth", 8'h0f, {4'h0, bw});
        rd(8'hc2, 8'h00);
        rd(8'hc3, 8'h00);
        ch_pin = 1'b0;
        settle();
        chk("view", 8'h90, view);
        ll_n = 1'b0;
        settle();
        chk("view", 8'h98, view);
        {ll_n, dl_n} = 2'h2;
        settle();
        chk("view", 8'h94, view);
        dl_n = 1'b1;
        // ratio from pins, every code
        for (int r = 0; r < 4; r++) begin
            {rp1, rp0} = r[1:0];
            settle();
            chk("ratio", 8'(r), {6'h0, ratio});
        end
        {rp1, rp0} = 2'h0;
        // register channel control overrides the pin
        wr(7'h50, 1'b1, 8'hc2, 8'hc0, 1'b1);
        chk("view", 8'he0, view);
        ch_pin = 1'b1;
        wr(7'h50, 1'b1, 8'hc2, 8'h80, 1'b1);
        chk("view", 8'h90, view);
        rd(8'hc2, 8'h80);
        // both limiters awake, still one route
        wr(7'h50, 1'b1, 8'hc2, 8'h20, 1'b1);
        chk("view", 8'hf0, view);
        ch_pin = 1'b0;
        settle();
        chk("view", 8'hb0, view);
        // bandwidth override and back to automatic
        wr(7'h50, 1'b1, 8'hc2, 8'h15, 1'b1);
        chk("bandwidth", 8'h05, {4'h0, bw});
        wr(7'h50, 1'b1, 8'hc2, 8'h00, 1'b1);
        chk("bandwidth", 8'h0f, {4'h0, bw});
        // ratio from register, then back to pins
        wr(7'h50, 1'b1, 8'hc3, 8'h82, 1'b1);
        chk("ratio", 8'h02, {6'h0, ratio});
        wr(7'h50, 1'b1, 8'hc3, 8'h03, 1'b1);
        chk("ratio", 8'h00, {6'h0, ratio});
        // foreign addresses and a deselected device change nothing
        wr(7'h51, 1'b1, 8'hc2, 8'h80, 1'b0);
        wr(7'h10, 1'b1, 8'hc2, 8'h80, 1'b0);
        wr(7'h50, 1'b0, 8'hc2, 8'h80, 1'b0);
        rd(8'hc2, 8'h00);
        // preset mode: rate pins decoded, registers ignored
        wr(7'h50, 1'b1, 8'hc2, 8'h80, 1'b1);
        ch_pin = 1'b1;
        ui = 1'b0;
        for (int r = 0; r < 8; r++) begin
            host_u.pins(r[2:0]);
            settle();
            chk("rate", 8'(r), {5'h0, rate_code});
            chk("view", 8'h60, view);
        end
        // power-on restore with the mode pin low
        rstn = 1'b0;
        settle();
        rstn = 1'b1;
        host_u.pins(3'h6);
        ui = 1'b1;
        settle();
        rd(8'hc2, 8'h00);
        wrap_up();
    end
endmodule
`default_nettype wire
